// ==== design/ipqm_bank.sv ====
// module: protocol filter values and codepoint-to-queue map with avalon-mm slave
// Notes on behaviour
// - bits 15:8 of each protocol pair hold the read/write value for filters 1, 3, 5 and 7.
// - bits 7:0 of each protocol pair hold the read/write value for filters 0, 2, 4 and 6.
// - an ip frame's codepoint bits 3:0 index the map when bits 5:4 are zero, and the indexed field is its queue.
// - a 2-bit map field names its queue directly, 00 to queue 0 through 11 to queue 3.
// - the map at 6C holds codepoints 000000 to 000111, codepoint n in bits 2n+1:2n.
// - the map at 6D holds codepoints 001000 to 001111 in successive 2-bit fields.
// - both map registers reset to zero so every covered codepoint goes to queue 0.
// - protocol pairs are 16-bit registers, all four resetting to zero, 5/4 at 69 and 7/6 at 6A.
`timescale 1ns/1ps
`default_nettype none

module ipqm_bank (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       reset_n,
  // avalon-mm slave
  input  wire logic [ipqm_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  output logic      [1:0]                 avs_response,
  // classifier side
  input  wire ipqm_pkg::ipqm_frame_t      frame_in,
  output var ipqm_pkg::ipqm_result_t      result_out
);

  localparam int FIELDS_PER_MAP = ipqm_pkg::REG_W / ipqm_pkg::QUEUE_W;
  localparam int NUM_CP         = 2 * FIELDS_PER_MAP;

  // register storage, one word per slot
  logic [ipqm_pkg::REG_W-1:0]       regs_r [ipqm_pkg::NUM_REGS];

  // bus handshake
  logic                             ack_r;
  logic [31:0]                      rdata_r;
  logic [1:0]                       resp_r;
  logic                             req;
  logic                             first_cycle;
  logic                             hit;
  logic [2:0]                       slot;
  logic [ipqm_pkg::NUM_REGS-1:0]    wr_sel;
  logic                             wr_hi_lane;
  logic                             wr_lo_lane;
  logic [31:0]                      rdata_nxt;
  logic [1:0]                       resp_nxt;

  // classifier
  ipqm_pkg::ipqm_result_t           result_r;
  ipqm_pkg::ipqm_result_t           result_nxt;
  logic                             frame_is_ip;
  logic                             cp_in_range;
  logic [ipqm_pkg::NUM_FILTERS-1:0] filter_eq;
  logic [ipqm_pkg::PROTO_W-1:0]     odd_filter_proto_value [ipqm_pkg::NUM_PAIRS];
  logic [ipqm_pkg::PROTO_W-1:0]     even_filter_proto_value [ipqm_pkg::NUM_PAIRS];
  logic [ipqm_pkg::PROTO_W-1:0]     filter_value [ipqm_pkg::NUM_FILTERS];
  logic [ipqm_pkg::QUEUE_W-1:0]     cp_queue [NUM_CP];

  // named views of the registers
  logic [ipqm_pkg::REG_W-1:0]       ip_proto_match_pair_a;
  logic [ipqm_pkg::REG_W-1:0]       ip_proto_match_pair_b;
  logic [ipqm_pkg::REG_W-1:0]       ip_proto_match_pair_c;
  logic [ipqm_pkg::REG_W-1:0]       ip_proto_match_pair_d;
  logic [ipqm_pkg::REG_W-1:0]       codepoint_queue_map_low;
  logic [ipqm_pkg::REG_W-1:0]       codepoint_queue_map_next;

  // named views of the map fields
  logic [ipqm_pkg::QUEUE_W-1:0]     queue_for_codepoint_00;
  logic [ipqm_pkg::QUEUE_W-1:0]     queue_for_codepoint_01;
  logic [ipqm_pkg::QUEUE_W-1:0]     queue_for_codepoint_02;
  logic [ipqm_pkg::QUEUE_W-1:0]     queue_for_codepoint_03;
  logic [ipqm_pkg::QUEUE_W-1:0]     queue_for_codepoint_04;
  logic [ipqm_pkg::QUEUE_W-1:0]     queue_for_codepoint_05;
  logic [ipqm_pkg::QUEUE_W-1:0]     queue_for_codepoint_06;
  logic [ipqm_pkg::QUEUE_W-1:0]     queue_for_codepoint_07;
  logic [ipqm_pkg::QUEUE_W-1:0]     queue_for_codepoint_08;
  logic [ipqm_pkg::QUEUE_W-1:0]     queue_for_codepoint_09;
  logic [ipqm_pkg::QUEUE_W-1:0]     queue_for_codepoint_10;
  logic [ipqm_pkg::QUEUE_W-1:0]     queue_for_codepoint_11;
  logic [ipqm_pkg::QUEUE_W-1:0]     queue_for_codepoint_12;
  logic [ipqm_pkg::QUEUE_W-1:0]     queue_for_codepoint_13;
  logic [ipqm_pkg::QUEUE_W-1:0]     queue_for_codepoint_14;
  logic [ipqm_pkg::QUEUE_W-1:0]     queue_for_codepoint_15;

  // address decode: slot and hit for a byte address
  function automatic logic [3:0] decode(input logic [ipqm_pkg::ADDR_W-1:0] a);
    logic [7:0] idx;
    logic [3:0] r;
    idx = a[ipqm_pkg::ADDR_W-1:2];
    r   = 4'h0;
    // misaligned addresses never hit
    if (a[1:0] == 2'h0) begin
      case (idx)
        ipqm_pkg::IDX_PAIR_A: begin
          r = {1'b1, ipqm_pkg::SLOT_PAIR_A};
        end
        ipqm_pkg::IDX_PAIR_B: begin
          r = {1'b1, ipqm_pkg::SLOT_PAIR_B};
        end
        ipqm_pkg::IDX_PAIR_C: begin
          r = {1'b1, ipqm_pkg::SLOT_PAIR_C};
        end
        ipqm_pkg::IDX_PAIR_D: begin
          r = {1'b1, ipqm_pkg::SLOT_PAIR_D};
        end
        ipqm_pkg::IDX_MAP_LOW: begin
          r = {1'b1, ipqm_pkg::SLOT_MAP_LOW};
        end
        ipqm_pkg::IDX_MAP_NEXT: begin
          r = {1'b1, ipqm_pkg::SLOT_MAP_NEXT};
        end
        default: begin
          r = 4'h0;
        end
      endcase
    end
    return r;
  endfunction

  assign req             = avs_read | avs_write;
  assign first_cycle     = req & ~ack_r;
  assign {hit, slot}     = decode(avs_address);
  // one wait cycle, then answer
  assign avs_waitrequest = first_cycle;
  assign avs_readdata    = rdata_r;
  assign avs_response    = resp_r;
  assign result_out      = result_r;
  // byte lanes above 1 are ignored
  assign wr_hi_lane      = avs_byteenable[1];
  assign wr_lo_lane      = avs_byteenable[0];

  assign ip_proto_match_pair_a    = regs_r[ipqm_pkg::SLOT_PAIR_A];
  assign ip_proto_match_pair_b    = regs_r[ipqm_pkg::SLOT_PAIR_B];
  assign ip_proto_match_pair_c    = regs_r[ipqm_pkg::SLOT_PAIR_C];
  assign ip_proto_match_pair_d    = regs_r[ipqm_pkg::SLOT_PAIR_D];
  assign codepoint_queue_map_low  = regs_r[ipqm_pkg::SLOT_MAP_LOW];
  assign codepoint_queue_map_next = regs_r[ipqm_pkg::SLOT_MAP_NEXT];

  assign queue_for_codepoint_00 = cp_queue[0];
  assign queue_for_codepoint_01 = cp_queue[1];
  assign queue_for_codepoint_02 = cp_queue[2];
  assign queue_for_codepoint_03 = cp_queue[3];
  assign queue_for_codepoint_04 = cp_queue[4];
  assign queue_for_codepoint_05 = cp_queue[5];
  assign queue_for_codepoint_06 = cp_queue[6];
  assign queue_for_codepoint_07 = cp_queue[7];
  assign queue_for_codepoint_08 = cp_queue[8];
  assign queue_for_codepoint_09 = cp_queue[9];
  assign queue_for_codepoint_10 = cp_queue[10];
  assign queue_for_codepoint_11 = cp_queue[11];
  assign queue_for_codepoint_12 = cp_queue[12];
  assign queue_for_codepoint_13 = cp_queue[13];
  assign queue_for_codepoint_14 = cp_queue[14];
  assign queue_for_codepoint_15 = cp_queue[15];

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= first_cycle;
    end
  end

  // read mux over the named views
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    resp_nxt  = hit ? ipqm_pkg::RESP_OKAY : ipqm_pkg::RESP_DECERR;
    if (avs_read && hit) begin
      case (slot)
        ipqm_pkg::SLOT_PAIR_A: begin
          rdata_nxt = {16'h0000, ip_proto_match_pair_a};
        end
        ipqm_pkg::SLOT_PAIR_B: begin
          rdata_nxt = {16'h0000, ip_proto_match_pair_b};
        end
        ipqm_pkg::SLOT_PAIR_C: begin
          rdata_nxt = {16'h0000, ip_proto_match_pair_c};
        end
        ipqm_pkg::SLOT_PAIR_D: begin
          rdata_nxt = {16'h0000, ip_proto_match_pair_d};
        end
        ipqm_pkg::SLOT_MAP_LOW: begin
          rdata_nxt = {16'h0000, codepoint_queue_map_low};
        end
        ipqm_pkg::SLOT_MAP_NEXT: begin
          rdata_nxt = {16'h0000, codepoint_queue_map_next};
        end
        default: begin
          rdata_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdata_r <= 32'h0000_0000;
      resp_r  <= ipqm_pkg::RESP_OKAY;
    end else if (first_cycle) begin
      resp_r  <= resp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // register writes land at the edge where waitrequest is low
  genvar g;
  generate
    for (g = 0; g < ipqm_pkg::NUM_REGS; g++) begin : g_reg
      localparam logic [15:0] RST = (g < ipqm_pkg::NUM_PAIRS) ? ipqm_pkg::RST_PAIR
                                                             : ipqm_pkg::RST_MAP;
      assign wr_sel[g] = avs_write & ack_r & hit & (slot == 3'(g));
      always_ff @(posedge mclk) begin
        if (!reset_n) begin
          regs_r[g] <= RST;
        end else if (wr_sel[g]) begin
          if (wr_hi_lane) begin
            regs_r[g][15:8] <= avs_writedata[15:8];
          end
          if (wr_lo_lane) begin
            regs_r[g][7:0] <= avs_writedata[7:0];
          end
        end
      end
    end
  endgenerate

  // filter values, two per pair register
  genvar p;
  generate
    for (p = 0; p < ipqm_pkg::NUM_PAIRS; p++) begin : g_pair
      assign odd_filter_proto_value[p] =
        regs_r[p][ipqm_pkg::ODD_LSB +: ipqm_pkg::PROTO_W];
      assign even_filter_proto_value[p] =
        regs_r[p][ipqm_pkg::EVEN_LSB +: ipqm_pkg::PROTO_W];
      assign filter_value[2*p+1] = odd_filter_proto_value[p];
      assign filter_value[2*p]   = even_filter_proto_value[p];
    end
  endgenerate

  genvar k;
  generate
    for (k = 0; k < ipqm_pkg::NUM_FILTERS; k++) begin : g_filter
      assign filter_eq[k] = (filter_value[k] == frame_in.proto);
    end
  endgenerate

  // map fields, eight per map register
  genvar c;
  generate
    for (c = 0; c < NUM_CP; c++) begin : g_cp
      if (c < FIELDS_PER_MAP) begin : g_low
        assign cp_queue[c] =
          codepoint_queue_map_low[ipqm_pkg::QUEUE_W*c +: ipqm_pkg::QUEUE_W];
      end else begin : g_next
        assign cp_queue[c] =
          codepoint_queue_map_next[ipqm_pkg::QUEUE_W*(c-FIELDS_PER_MAP) +: ipqm_pkg::QUEUE_W];
      end
    end
  endgenerate

  assign frame_is_ip = frame_in.frame_valid & frame_in.is_ip;
  // codepoints above 001111 belong to other map registers
  assign cp_in_range = (frame_in.codepoint[5:4] == 2'h0);

  // classifier lookup, registered one cycle after the frame strobe
  always_comb begin
    result_nxt             = '0;
    result_nxt.valid       = frame_in.frame_valid;
    result_nxt.proto_match = {ipqm_pkg::NUM_FILTERS{frame_is_ip}} & filter_eq;
    result_nxt.queue_hit   = frame_is_ip & cp_in_range;
    if (result_nxt.queue_hit) begin
      case (frame_in.codepoint[3:0])
        4'h0: begin
          result_nxt.queue = queue_for_codepoint_00;
        end
        4'h1: begin
          result_nxt.queue = queue_for_codepoint_01;
        end
        4'h2: begin
          result_nxt.queue = queue_for_codepoint_02;
        end
        4'h3: begin
          result_nxt.queue = queue_for_codepoint_03;
        end
        4'h4: begin
          result_nxt.queue = queue_for_codepoint_04;
        end
        4'h5: begin
          result_nxt.queue = queue_for_codepoint_05;
        end
        4'h6: begin
          result_nxt.queue = queue_for_codepoint_06;
        end
        4'h7: begin
          result_nxt.queue = queue_for_codepoint_07;
        end
        4'h8: begin
          result_nxt.queue = queue_for_codepoint_08;
        end
        4'h9: begin
          result_nxt.queue = queue_for_codepoint_09;
        end
        4'hA: begin
          result_nxt.queue = queue_for_codepoint_10;
        end
        4'hB: begin
          result_nxt.queue = queue_for_codepoint_11;
        end
        4'hC: begin
          result_nxt.queue = queue_for_codepoint_12;
        end
        4'hD: begin
          result_nxt.queue = queue_for_codepoint_13;
        end
        4'hE: begin
          result_nxt.queue = queue_for_codepoint_14;
        end
        4'hF: begin
          result_nxt.queue = queue_for_codepoint_15;
        end
        default: begin
          result_nxt.queue = 2'h0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      result_r <= '0;
    end else begin
      result_r <= result_nxt;
    end
  end

endmodule

`default_nettype wire

// ==== design/ipqm_pkg.sv ====
// package: register map, field layout and carrier types for the ip protocol / codepoint queue bank
package ipqm_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_PAIR_A   = 8'h68;
  localparam logic [7:0] IDX_PAIR_B   = 8'h6B;
  localparam logic [7:0] IDX_PAIR_C   = 8'h69;
  localparam logic [7:0] IDX_PAIR_D   = 8'h6A;
  localparam logic [7:0] IDX_MAP_LOW  = 8'h6C;
  localparam logic [7:0] IDX_MAP_NEXT = 8'h6D;

  localparam int         NUM_REGS     = 6;
  localparam int         NUM_PAIRS    = 4;
  localparam int         NUM_FILTERS  = 8;
  localparam int         ADDR_W       = 10;
  localparam int         REG_W        = 16;

  // slots of the register array
  localparam logic [2:0] SLOT_PAIR_A   = 3'h0;
  localparam logic [2:0] SLOT_PAIR_B   = 3'h1;
  localparam logic [2:0] SLOT_PAIR_C   = 3'h2;
  localparam logic [2:0] SLOT_PAIR_D   = 3'h3;
  localparam logic [2:0] SLOT_MAP_LOW  = 3'h4;
  localparam logic [2:0] SLOT_MAP_NEXT = 3'h5;

  // field positions
  localparam int         ODD_LSB      = 8;
  localparam int         EVEN_LSB     = 0;
  localparam int         PROTO_W      = 8;
  localparam int         QUEUE_W      = 2;
  localparam int         CODEPOINT_W  = 6;

  // reset values
  localparam logic [15:0] RST_PAIR    = 16'h0000;
  localparam logic [15:0] RST_MAP     = 16'h0000;

  // avalon response codes
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_DECERR  = 2'h3;

  typedef struct packed {
    logic                    frame_valid;
    logic                    is_ip;
    logic [PROTO_W-1:0]      proto;
    logic [CODEPOINT_W-1:0]  codepoint;
  } ipqm_frame_t;

  typedef struct packed {
    logic                    valid;
    logic [NUM_FILTERS-1:0]  proto_match;
    logic                    queue_hit;
    logic [QUEUE_W-1:0]      queue;
  } ipqm_result_t;

endpackage

// ==== test/ipqm_bank_chk.sv ====
// checker: port assertions for the queue map bank
`timescale 1ns/1ps
`default_nettype none
module ipqm_bank_chk (
  input wire logic                   mclk,
  input wire logic                   reset_n,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic                   avs_waitrequest,
  input wire ipqm_pkg::ipqm_frame_t  frame_in,
  input wire ipqm_pkg::ipqm_result_t result_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire fv = frame_in.frame_valid;
  wire ip = fv & frame_in.is_ip;
  AST_NOIP: assert property (fv && !frame_in.is_ip |=> result_out.proto_match == 8'h00)
    else $error("match without ip");
  AST_HICP: assert property (fv && frame_in.codepoint[5:4] != 2'h0 |=> !result_out.queue_hit)
    else $error("hit above 15");
  AST_LOCP: assert property (ip && frame_in.codepoint[5:4] == 2'h0 |=> result_out.queue_hit)
    else $error("miss below 16");
  AST_LAT: assert property (result_out.valid == $past(fv))
    else $error("result latency");
  AST_QIDLE: assert property (!result_out.queue_hit |-> result_out.queue == 2'h0)
    else $error("queue without hit");
  AST_MSTB: assert property (
    ip && !avs_write ##1 ip && !avs_write && $stable(frame_in.proto)
    |=> $stable(result_out.proto_match)) else $error("match drift");
  AST_QSTB: assert property (
    ip && !avs_write ##1 ip && !avs_write && $stable(frame_in.codepoint)
    |=> $stable(result_out.queue)) else $error("queue drift");
  AST_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait too long");
endmodule
bind ipqm_bank ipqm_bank_chk i_ipqm_bank_chk (.mclk, .reset_n, .avs_read, .avs_write,
  .avs_waitrequest, .frame_in, .result_out);
`default_nettype wire

// ==== test/ipqm_bank_test.sv ====
// testbench: register and classifier checks for the queue map bank
`timescale 1ns/1ps
`default_nettype none
module ipqm_bank_test;
  logic                   mclk = 1'b0;
  logic                   reset_n = 1'b0;
  logic                   avs_read = 1'b0;
  logic                   avs_write = 1'b0;
  logic                   avs_waitrequest;
  logic [1:0]             avs_response;
  logic [9:0]             avs_address = 10'h000;
  logic [3:0]             avs_byteenable = 4'h3, be_sel = 4'h3;
  logic [31:0]            avs_writedata = 32'h0, avs_readdata;
  ipqm_pkg::ipqm_frame_t  frame_in = '0;
  ipqm_pkg::ipqm_result_t result_out;
  int                     error_cnt = 0, check_count = 0;
  logic [7:0]             idx [6] = '{8'h68, 8'h6B, 8'h69, 8'h6A, 8'h6C, 8'h6D};
  logic [15:0]            val [6] = '{16'h1106, 16'h3332, 16'h5554, 16'h7776, 16'hE4E4, 16'h1B1B};
  logic [15:0]            mp;
  always #2.5 mclk = ~mclk;
  ipqm_bank i_ipqm_bank (.mclk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .frame_in, .result_out);
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(logic w, logic [7:0] a, logic [15:0] d);
    @(posedge mclk);
    avs_address <= {a, 2'h0};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be_sel;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    mp = avs_readdata[15:0];
    chk({14'h0000, avs_response, avs_readdata[31:16]}, {14'h0000, a[4], a[4], 16'h0000});
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // frame held two cycles, second result checked
  task automatic fr(logic ip, logic [7:0] p, logic [5:0] cp, logic [11:0] exp);
    @(posedge mclk);
    frame_in <= {1'b1, ip, p, cp};
    repeat (2) @(posedge mclk);
    frame_in <= '0;
    #1 chk(32'(result_out), 32'(exp));
  endtask
  task automatic results;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    results();
  end
  initial begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    fr(1'b1, 8'h00, 6'h05, {1'b1, 8'hFF, 1'b1, 2'h0});
    foreach (idx[i]) begin
      acc(1'b0, idx[i], 16'h0000);
      chk(mp, 32'h0);
    end
    foreach (idx[i]) acc(1'b1, idx[i], val[i]);
    foreach (idx[i]) begin
      acc(1'b0, idx[i], 16'h0000);
      chk(mp, val[i]);
    end
    acc(1'b0, 8'h70, 16'h0000);
    fr(1'b1, 8'h55, 6'h3F, {1'b1, 8'h20, 1'b0, 2'h0});
    fr(1'b1, 8'h11, 6'h10, {1'b1, 8'h02, 1'b0, 2'h0});
    fr(1'b1, 8'h32, 6'h20, {1'b1, 8'h04, 1'b0, 2'h0});
    fr(1'b0, 8'h55, 6'h00, {1'b1, 8'h00, 1'b0, 2'h0});
    for (int c = 0; c < 16; c++) begin
      mp = (c < 8) ? val[4] : val[5];
      fr(1'b1, 8'h76, c[5:0], {1'b1, 8'h40, 1'b1, mp[2*(c%8) +: 2]});
    end
    acc(1'b1, 8'h70, 16'hFFFF);
    be_sel = 4'h2;
    acc(1'b1, 8'h68, 16'hABCD);
    be_sel = 4'h3;
    acc(1'b0, 8'h68, 16'h0000);
    chk(mp, 32'h0000_AB06);
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    foreach (idx[i]) begin
      acc(1'b0, idx[i], 16'h0000);
      chk(mp, 32'h0);
    end
    fr(1'b1, 8'h00, 6'h0F, {1'b1, 8'hFF, 1'b1, 2'h0});
    results();
  end
endmodule
`default_nettype wire
